// ### hw/frt_timer.sv
// Purpose: 16-bit free-running timer with two captures and two compares
// Assumes: Avalon-MM slave, byte registers in bits 7:0 of each word
// Notes: pins are synchronised on the rising cpu clock edge
module frt_timer (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [5:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [3:0] byteenable_in,
    input wire logic [31:0] writedata_in,
    output logic [31:0] readdata_out,
    output logic waitrequest_out,
    input wire logic global_irq_mask_in,
    input wire logic halt_in,
    input wire logic ext_clock_pin_in,
    input wire logic [1:0] capture_pin_in,
    output logic [1:0] compare_pin_out,
    output logic [1:0] compare_pin_oe_out,
    output logic timer_irq_out
);

    // ==========================================================
    // pin synchronisation and internal prescaler
    frt_pkg::frt_state_t s_q;
    frt_pkg::frt_state_t s_d;
    logic [2:0] pin_sync;
    logic presc_tick;
    logic [1:0] clk_sel;

    assign clk_sel = s_q.ctrl_two[frt_pkg::FRT_C2_CLK_SEL +: 2];

    // capture pins are sampled straight from the pads whatever the
    // port direction, so driving one as an output can trigger it
    // sampling on the rising edge adds up to half a cycle of latency,
    // traded for a single clock edge in the whole block
    frt_sync #(
        .WIDTH(3)
    ) u_sync (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .async_in({capture_pin_in, ext_clock_pin_in}),
        .sync_out(pin_sync)
    );

    frt_prescale u_presc (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .run_in(!halt_in),
        .ratio_sel_in(clk_sel),
        .tick_out(presc_tick)
    );

    // ==========================================================
    // next-state logic
    always_comb begin
        logic accept;
        logic rd;
        logic wr;
        logic [3:0] sel;
        logic [7:0] wdat;
        logic [7:0] rbyte;
        logic ext_sync;
        logic ext_edge;
        logic tick;
        logic reload;
        logic lo_access_p;
        logic [1:0] cap_sync;
        logic [1:0] cap_edge_sel;
        logic [1:0] cmp_level;
        logic [1:0] cmp_oe;
        logic pulse_modes;
        logic cap_hit;
        logic cmp_hit;
        logic [3:0] hi_idx;
        logic [3:0] lo_idx;
        logic irq_req;

        s_d = s_q;
        accept = (read_in || write_in) && s_q.waitreq;
        rd = accept && read_in;
        wr = accept && write_in && byteenable_in[0];
        sel = address_in[5:2];
        wdat = writedata_in[7:0];
        rbyte = 8'h00;
        ext_sync = pin_sync[0];
        cap_sync = pin_sync[2:1];
        cap_edge_sel[0] = s_q.ctrl_one[frt_pkg::FRT_C1_CAP_EDGE1];
        cap_edge_sel[1] = s_q.ctrl_two[frt_pkg::FRT_C2_CAP_EDGE2];
        cmp_level[0] = s_q.ctrl_one[frt_pkg::FRT_C1_CMP_LVL1];
        cmp_level[1] = s_q.ctrl_one[frt_pkg::FRT_C1_CMP_LVL2];
        cmp_oe[0] = s_q.ctrl_two[frt_pkg::FRT_C2_CMP_OE1];
        cmp_oe[1] = s_q.ctrl_two[frt_pkg::FRT_C2_CMP_OE2];
        pulse_modes = s_q.ctrl_two[frt_pkg::FRT_C2_PULSE] || s_q.ctrl_two[frt_pkg::FRT_C2_PWM];
        cap_hit = 1'b0;
        cmp_hit = 1'b0;
        hi_idx = 4'h0;
        lo_idx = 4'h0;
        ext_edge = 1'b0;
        tick = 1'b0;
        reload = 1'b0;
        lo_access_p = 1'b0;
        irq_req = 1'b0;

        // ------------------------------------------------------
        // bus handshake: one wait cycle, the access happens at accept
        // a fixed wait state means side effects need no extra pipeline
        s_d.waitreq = !accept;

        // ------------------------------------------------------
        // read multiplexer
        case (sel)
            frt_pkg::FRT_IDX_CTRL_ONE: rbyte = s_q.ctrl_one;
            frt_pkg::FRT_IDX_CTRL_TWO: rbyte = s_q.ctrl_two;
            frt_pkg::FRT_IDX_STATUS: rbyte = {3'h0, s_q.cmp_flag, s_q.cap_flag, s_q.ovf_flag};
            frt_pkg::FRT_IDX_CNT_HI_P: rbyte = s_q.count[15:8];
            frt_pkg::FRT_IDX_CNT_HI_A: rbyte = s_q.count[15:8];
            frt_pkg::FRT_IDX_CNT_LO_P: rbyte = s_q.lo_held ? s_q.lo_buf : s_q.count[7:0];
            frt_pkg::FRT_IDX_CNT_LO_A: rbyte = s_q.lo_held ? s_q.lo_buf : s_q.count[7:0];
            default: rbyte = 8'h00;
        endcase
        for (int i = 0; i < 2; i++) begin
            hi_idx = 4'(frt_pkg::FRT_IDX_CAP_HI + 2 * i);
            lo_idx = 4'(frt_pkg::FRT_IDX_CAP_HI + 2 * i + 1);
            if (sel == hi_idx) begin
                rbyte = s_q.cap_val[i][15:8];
            end
            if (sel == lo_idx) begin
                rbyte = s_q.cap_val[i][7:0];
            end
            hi_idx = 4'(frt_pkg::FRT_IDX_CMP_HI + 2 * i);
            lo_idx = 4'(frt_pkg::FRT_IDX_CMP_HI + 2 * i + 1);
            if (sel == hi_idx) begin
                rbyte = s_q.cmp_val[i][15:8];
            end
            if (sel == lo_idx) begin
                rbyte = s_q.cmp_val[i][7:0];
            end
        end
        if (rd) begin
            s_d.rdata = {24'h000000, rbyte};
        end

        // ------------------------------------------------------
        // counter read pairing, shared by primary and alternate views
        if (rd && (sel == frt_pkg::FRT_IDX_CNT_HI_P || sel == frt_pkg::FRT_IDX_CNT_HI_A)) begin
            // a second high read must not refresh the buffer
            if (!s_q.lo_held) begin
                s_d.lo_buf = s_q.count[7:0];
                s_d.lo_held = 1'b1;
            end
        end
        if (rd && (sel == frt_pkg::FRT_IDX_CNT_LO_P || sel == frt_pkg::FRT_IDX_CNT_LO_A)) begin
            s_d.lo_held = 1'b0;
        end

        // ------------------------------------------------------
        // first step of flag clearing: arm what the status read saw set
        if (rd && sel == frt_pkg::FRT_IDX_STATUS) begin
            s_d.ovf_arm = s_q.ovf_arm || s_q.ovf_flag;
            s_d.cap_arm = s_q.cap_arm | s_q.cap_flag;
            s_d.cmp_arm = s_q.cmp_arm | s_q.cmp_flag;
        end

        // second step for overflow: only the primary low register counts
        lo_access_p = (rd || (accept && write_in)) && sel == frt_pkg::FRT_IDX_CNT_LO_P;
        if (lo_access_p && s_q.ovf_arm) begin
            s_d.ovf_flag = 1'b0;
            s_d.ovf_arm = 1'b0;
        end

        // ------------------------------------------------------
        // control writes and counter reload
        reload = wr && (sel == frt_pkg::FRT_IDX_CNT_LO_P || sel == frt_pkg::FRT_IDX_CNT_LO_A);
        if (wr && sel == frt_pkg::FRT_IDX_CTRL_ONE) begin
            s_d.ctrl_one = wdat;
        end
        if (wr && sel == frt_pkg::FRT_IDX_CTRL_TWO) begin
            s_d.ctrl_two = wdat;
        end

        // ------------------------------------------------------
        // per-channel register access
        for (int i = 0; i < 2; i++) begin
            hi_idx = 4'(frt_pkg::FRT_IDX_CAP_HI + 2 * i);
            lo_idx = 4'(frt_pkg::FRT_IDX_CAP_HI + 2 * i + 1);
            if (rd && sel == hi_idx) begin
                s_d.cap_block[i] = 1'b1;
            end
            if (rd && sel == lo_idx) begin
                s_d.cap_block[i] = 1'b0;
            end
            if ((rd || (accept && write_in)) && sel == lo_idx && s_q.cap_arm[i]) begin
                s_d.cap_flag[i] = 1'b0;
                s_d.cap_arm[i] = 1'b0;
            end
            hi_idx = 4'(frt_pkg::FRT_IDX_CMP_HI + 2 * i);
            lo_idx = 4'(frt_pkg::FRT_IDX_CMP_HI + 2 * i + 1);
            if (wr && sel == hi_idx) begin
                s_d.cmp_val[i][15:8] = wdat;
                s_d.cmp_inhibit[i] = 1'b1;
            end
            if (wr && sel == lo_idx) begin
                s_d.cmp_val[i][7:0] = wdat;
                s_d.cmp_inhibit[i] = 1'b0;
                s_d.cmp_flag[i] = 1'b0;
                s_d.cmp_arm[i] = 1'b0;
            end
            if (rd && sel == lo_idx && s_q.cmp_arm[i]) begin
                s_d.cmp_flag[i] = 1'b0;
                s_d.cmp_arm[i] = 1'b0;
            end
        end

        // ------------------------------------------------------
        // timer clock: prescaler or qualified external edge
        // the source must leave two cpu cycles between active edges
        // for every edge to be seen after synchronisation
        ext_edge = s_q.ctrl_two[frt_pkg::FRT_C2_EXT_EDGE] ? (ext_sync && !s_q.ext_prev)
                                                         : (!ext_sync && s_q.ext_prev);
        s_d.ext_prev = ext_sync;
        if (clk_sel == frt_pkg::FRT_CLK_EXTERNAL) begin
            tick = ext_edge && !halt_in;
        end else begin
            tick = presc_tick;
        end

        // ------------------------------------------------------
        // counter; hardware set of a flag comes after any clear
        // a reload beats a tick in the same cycle, so no false wrap
        if (reload) begin
            s_d.count = frt_pkg::FRT_COUNT_RELOAD;
        end else if (tick) begin
            s_d.count = s_q.count + 16'h0001;
            if (s_q.count == frt_pkg::FRT_COUNT_MAX) begin
                s_d.ovf_flag = 1'b1;
            end
        end

        // ------------------------------------------------------
        // capture and compare channels
        for (int i = 0; i < 2; i++) begin
            cap_hit = cap_edge_sel[i] ? (cap_sync[i] && !s_q.cap_prev[i])
                                      : (!cap_sync[i] && s_q.cap_prev[i]);
            // channel one belongs to the waveform modes while they run
            if (i == 0 && pulse_modes) begin
                cap_hit = 1'b0;
            end
            if (cap_hit && !s_q.cap_block[i]) begin
                s_d.cap_val[i] = s_q.count;
                s_d.cap_flag[i] = 1'b1;
            end
            // the compare sees the count before this tick advances it, so
            // flag and pin appear as the counter moves one past the match
            cmp_hit = tick && !s_q.cmp_inhibit[i] && s_q.count == s_q.cmp_val[i];
            if (cmp_hit) begin
                s_d.cmp_flag[i] = 1'b1;
                if (cmp_oe[i]) begin
                    s_d.cmp_pin[i] = cmp_level[i];
                end
            end
        end
        s_d.cap_prev = cap_sync;

        // ------------------------------------------------------
        // interrupt request stays pending while masked
        // registered, so the request trails its flag by one cycle
        irq_req = (s_q.ovf_flag && s_q.ctrl_one[frt_pkg::FRT_C1_OVF_IE])
            || ((|s_q.cap_flag) && s_q.ctrl_one[frt_pkg::FRT_C1_CAP_IE])
            || ((|s_q.cmp_flag) && s_q.ctrl_one[frt_pkg::FRT_C1_CMP_IE]);
        s_d.irq = irq_req && !global_irq_mask_in;
    end

    // ==========================================================
    // state register
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            s_q.ctrl_one <= frt_pkg::FRT_CTRL_RESET;
            s_q.ctrl_two <= frt_pkg::FRT_CTRL_RESET;
            s_q.count <= frt_pkg::FRT_COUNT_RELOAD;
            s_q.ovf_flag <= 1'b0;
            s_q.ovf_arm <= 1'b0;
            s_q.lo_buf <= 8'h00;
            s_q.lo_held <= 1'b0;
            s_q.cap_val <= '0;
            s_q.cap_flag <= 2'h0;
            s_q.cap_arm <= 2'h0;
            s_q.cap_block <= 2'h0;
            s_q.cap_prev <= 2'h0;
            s_q.cmp_val <= {frt_pkg::FRT_COMPARE_RESET, frt_pkg::FRT_COMPARE_RESET};
            s_q.cmp_flag <= 2'h0;
            s_q.cmp_arm <= 2'h0;
            s_q.cmp_inhibit <= 2'h0;
            s_q.cmp_pin <= 2'h0;
            s_q.ext_prev <= 1'b0;
            s_q.waitreq <= 1'b1;
            s_q.rdata <= 32'h00000000;
            s_q.irq <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs, all straight from flops
    assign readdata_out = s_q.rdata;
    assign waitrequest_out = s_q.waitreq;
    assign compare_pin_out = s_q.cmp_pin;
    assign compare_pin_oe_out = {s_q.ctrl_two[frt_pkg::FRT_C2_CMP_OE2],
                                 s_q.ctrl_two[frt_pkg::FRT_C2_CMP_OE1]};
    assign timer_irq_out = s_q.irq;

endmodule // frt_timer

// ### hw/frt_pkg.sv
// Purpose: shared constants and state type for the free-running timer block
// Assumes: byte-wide registers, each on one aligned 32-bit word
// Notes: register index times four is the byte address
package frt_pkg;

    // ==========================================================
    // register indices (byte address = index * 4)
    localparam logic [3:0] FRT_IDX_CTRL_ONE = 4'h0;
    localparam logic [3:0] FRT_IDX_CTRL_TWO = 4'h1;
    localparam logic [3:0] FRT_IDX_STATUS = 4'h2;
    localparam logic [3:0] FRT_IDX_CNT_HI_P = 4'h3;
    localparam logic [3:0] FRT_IDX_CNT_LO_P = 4'h4;
    localparam logic [3:0] FRT_IDX_CNT_HI_A = 4'h5;
    localparam logic [3:0] FRT_IDX_CNT_LO_A = 4'h6;
    // channel i high byte at base + 2*i, low byte one above
    localparam logic [3:0] FRT_IDX_CAP_HI = 4'h7;
    localparam logic [3:0] FRT_IDX_CMP_HI = 4'hb;

    // ==========================================================
    // timer_control_one fields
    localparam int FRT_C1_OVF_IE = 0;
    localparam int FRT_C1_CAP_IE = 1;
    localparam int FRT_C1_CMP_IE = 2;
    localparam int FRT_C1_CAP_EDGE1 = 3;
    localparam int FRT_C1_CMP_LVL1 = 4;
    localparam int FRT_C1_CMP_LVL2 = 5;
    // timer_control_two fields
    localparam int FRT_C2_CLK_SEL = 0;
    localparam int FRT_C2_EXT_EDGE = 2;
    localparam int FRT_C2_CAP_EDGE2 = 3;
    localparam int FRT_C2_CMP_OE1 = 4;
    localparam int FRT_C2_CMP_OE2 = 5;
    localparam int FRT_C2_PULSE = 6;
    localparam int FRT_C2_PWM = 7;

    // ==========================================================
    // reset and reload values
    localparam logic [7:0] FRT_CTRL_RESET = 8'h00;
    localparam logic [15:0] FRT_COUNT_RELOAD = 16'hfffc;
    localparam logic [15:0] FRT_COUNT_MAX = 16'hffff;
    localparam logic [15:0] FRT_COMPARE_RESET = 16'h8000;
    localparam logic [1:0] FRT_CLK_EXTERNAL = 2'h3;
    // prescaler masks (ratio minus one) for the three internal codes
    localparam logic [2:0] FRT_DIV_MASK_C0 = 3'h3;
    localparam logic [2:0] FRT_DIV_MASK_C1 = 3'h1;
    localparam logic [2:0] FRT_DIV_MASK_C2 = 3'h7;

    // ==========================================================
    typedef struct packed {
        logic [7:0] ctrl_one;
        logic [7:0] ctrl_two;
        logic [15:0] count;
        logic ovf_flag;
        logic ovf_arm;
        logic [7:0] lo_buf;
        logic lo_held;
        logic [1:0][15:0] cap_val;
        logic [1:0] cap_flag;
        logic [1:0] cap_arm;
        logic [1:0] cap_block;
        logic [1:0] cap_prev;
        logic [1:0][15:0] cmp_val;
        logic [1:0] cmp_flag;
        logic [1:0] cmp_arm;
        logic [1:0] cmp_inhibit;
        logic [1:0] cmp_pin;
        logic ext_prev;
        logic waitreq;
        logic [31:0] rdata;
        logic irq;
    } frt_state_t;

endpackage

// ### hw/frt_sync.sv
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: each bit is an independent level
// Notes: the first stage feeds only the second
module frt_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // frt_sync

// ### hw/frt_prescale.sv
// Purpose: internal timer clock as a one-cycle tick every 2, 4 or 8 cpu cycles
// Assumes: run low freezes the divider (halt)
// Notes: code to ratio mapping lives in the package masks
module frt_prescale (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic run_in,
    input wire logic [1:0] ratio_sel_in,
    output logic tick_out
);
    logic [2:0] div_q;
    logic [2:0] mask;

    always_comb begin
        case (ratio_sel_in)
            2'h0: mask = frt_pkg::FRT_DIV_MASK_C0;
            2'h1: mask = frt_pkg::FRT_DIV_MASK_C1;
            2'h2: mask = frt_pkg::FRT_DIV_MASK_C2;
            default: mask = frt_pkg::FRT_DIV_MASK_C0;
        endcase
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            div_q <= 3'h0;
            tick_out <= 1'b0;
        end else begin
            if (run_in) begin
                div_q <= div_q + 3'h1;
            end
            tick_out <= run_in && ((div_q & mask) == mask);
        end
    end
endmodule // frt_prescale

// ### verification/frt_timer_asserts.sv
// Purpose: concurrent checks on the timer's bus handshake, pins and interrupt
// Assumes: one clock domain, asynchronous active-high reset
// Notes: attached to every frt_timer instance by the bind below
module frt_timer_asserts (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [5:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [3:0] byteenable_in,
    input wire logic [31:0] writedata_in,
    input wire logic [31:0] readdata_out,
    input wire logic waitrequest_out,
    input wire logic global_irq_mask_in,
    input wire logic halt_in,
    input wire logic ext_clock_pin_in,
    input wire logic [1:0] capture_pin_in,
    input wire logic [1:0] compare_pin_out,
    input wire logic [1:0] compare_pin_oe_out,
    input wire logic timer_irq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // helpers
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    logic acc_seen;
    assign acc_seen = (read_in || write_in) && waitrequest_out;

    a_wait_one_low: assert property (acc_seen |=> !waitrequest_out ##1 waitrequest_out)
        else $error("waitrequest not low for exactly one cycle");
    a_wait_idle_high: assert property (!read_in && !write_in && waitrequest_out |=> waitrequest_out)
        else $error("waitrequest dropped with no request");
    a_read_upper_zero: assert property (!waitrequest_out |-> readdata_out[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_unmapped_reads_zero: assert property (acc_seen && read_in && address_in[5:2] == 4'hf
        |=> readdata_out == 32'h0)
        else $error("unmapped read not zero");
    a_status_unused_zero: assert property (acc_seen && read_in && address_in[5:2] == 4'h2
        |=> readdata_out[31:5] == 27'h0)
        else $error("status unused bits not zero");
    a_oe_tracks_ctrl: assert property (
        acc_seen && write_in && address_in[5:2] == 4'h1 && byteenable_in[0]
        |-> ##2 compare_pin_oe_out == $past(writedata_in[5:4], 2))
        else $error("compare output enable does not follow control");
    a_irq_when_masked: assert property (global_irq_mask_in |=> !timer_irq_out)
        else $error("interrupt raised while masked");
    a_pin_after_reset: assert property ($fell(rst_in) |-> compare_pin_out == 2'h0)
        else $error("compare pin not low out of reset");
endmodule // frt_timer_asserts

bind frt_timer frt_timer_asserts chk_u (
    .clock_in(clock_in), .rst_in(rst_in), .address_in(address_in), .read_in(read_in),
    .write_in(write_in), .byteenable_in(byteenable_in), .writedata_in(writedata_in),
    .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
    .global_irq_mask_in(global_irq_mask_in), .halt_in(halt_in),
    .ext_clock_pin_in(ext_clock_pin_in), .capture_pin_in(capture_pin_in),
    .compare_pin_out(compare_pin_out), .compare_pin_oe_out(compare_pin_oe_out),
    .timer_irq_out(timer_irq_out)
);

// ### verification/frt_pin_model.sv
// Purpose: external pulse source and capture sources facing the timer pins
// Assumes: bench requests bursts of external clock pulses and capture levels
// Notes: external clock stands low between bursts
module frt_pin_model (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic pulse_req_in,
    input wire logic [3:0] pulse_count_in,
    input wire logic [1:0] cap_level_in,
    output logic ext_clock_out,
    output logic [1:0] capture_out,
    output logic busy_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] left_q;
    logic [2:0] phase_q;
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            left_q <= 4'h0;
            phase_q <= 3'h0;
        end else if (pulse_req_in) begin
            left_q <= pulse_count_in;
            phase_q <= 3'h0;
        end else if (left_q != 4'h0) begin
            phase_q <= phase_q + 3'h1;
            if (phase_q == 3'h7) begin
                left_q <= left_q - 4'h1;
            end
        end
    end
    // four cycles high, four low: active edges stay eight cpu cycles apart
    assign ext_clock_out = (left_q != 4'h0) && !phase_q[2];
    // capture sources drive the pins at any time, like a toggled output
    assign capture_out = cap_level_in;
    assign busy_out = (left_q != 4'h0);
endmodule // frt_pin_model

// ### verification/tb_free_running_timer_capture_compare.sv
// Purpose: register-level tests of the free-running timer
// Assumes: external clock mode keeps the count still between bursts
// Notes: capture and compare values follow from the pulses sent
module tb_free_running_timer_capture_compare;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic [5:0] address = 6'h0;
    logic rd_req = 1'b0;
    logic wr_req = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic mask = 1'b1;
    logic halt = 1'b0;
    logic pulse_req = 1'b0;
    logic [3:0] pulse_n = 4'h0;
    logic [1:0] cap_lvl = 2'h0;
    logic ext_clk, busy, wait_req, irq;
    logic [1:0] cap_pin, cmp_pin, cmp_oe;
    logic [31:0] rdata;
    logic [7:0] d;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;

    initial begin
        forever #10 clock_in = ~clock_in;
    end

    frt_timer dut_u (.clock_in(clock_in), .rst_in(rst_in), .address_in(address),
        .read_in(rd_req), .write_in(wr_req), .byteenable_in(4'h1), .writedata_in(wdata),
        .readdata_out(rdata), .waitrequest_out(wait_req), .global_irq_mask_in(mask),
        .halt_in(halt), .ext_clock_pin_in(ext_clk), .capture_pin_in(cap_pin),
        .compare_pin_out(cmp_pin), .compare_pin_oe_out(cmp_oe), .timer_irq_out(irq));
    frt_pin_model pm_u (.clock_in(clock_in), .rst_in(rst_in), .pulse_req_in(pulse_req),
        .pulse_count_in(pulse_n), .cap_level_in(cap_lvl), .ext_clock_out(ext_clk),
        .capture_out(cap_pin), .busy_out(busy));

    // ==========================================================
    // bus and check tasks
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rd(input logic [3:0] idx, output logic [7:0] v);
        address <= {idx, 2'b00};
        rd_req <= 1'b1;
        @(posedge clock_in);
        while (wait_req !== 1'b0) @(posedge clock_in);
        v = rdata[7:0];
        rd_req <= 1'b0;
        @(posedge clock_in);
    endtask
    task automatic wr(input logic [3:0] idx, input logic [7:0] v);
        address <= {idx, 2'b00};
        wdata <= {24'h0, v};
        wr_req <= 1'b1;
        @(posedge clock_in);
        while (wait_req !== 1'b0) @(posedge clock_in);
        wr_req <= 1'b0;
        @(posedge clock_in);
    endtask
    task automatic rc(input logic [3:0] idx, input logic [7:0] exp, input string name);
        logic [7:0] v;
        rd(idx, v);
        chk(name, v, exp);
    endtask
    // settle time covers the pin synchroniser and edge detect
    task automatic pulses(input logic [3:0] n);
        pulse_req <= 1'b1;
        pulse_n <= n;
        @(posedge clock_in);
        pulse_req <= 1'b0;
        @(posedge clock_in);
        while (busy !== 1'b0) @(posedge clock_in);
        repeat (6) @(posedge clock_in);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            summarize();
        end
    end

    // ==========================================================
    // test sequence
    initial begin
        repeat (8) @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        rc(4'h0, 8'h00, "ctrl_one");
        rc(4'h1, 8'h00, "ctrl_two");
        rc(4'hb, 8'h80, "cmp1_hi");
        rc(4'hc, 8'h00, "cmp1_lo");
        rc(4'hd, 8'h80, "cmp2_hi");
        rc(4'hf, 8'h00, "unmapped");
        wr(4'h1, 8'h07);
        wr(4'h4, 8'h00);
        pulses(4'h2);
        rc(4'h3, 8'hff, "cnt_hi");
        pulses(4'h3);
        rc(4'h3, 8'h00, "cnt_hi_again");
        rc(4'h4, 8'hfe, "cnt_lo_buf");
        rc(4'h6, 8'h01, "cnt_lo_live");
        rc(4'h2, 8'h01, "status_ovf");
        rc(4'h6, 8'h01, "alt_lo");
        rc(4'h2, 8'h01, "status_kept");
        rc(4'h4, 8'h01, "prim_lo");
        rc(4'h2, 8'h00, "status_clr");
        halt <= 1'b1;
        pulses(4'h3);
        halt <= 1'b0;
        rc(4'h6, 8'h01, "halt_hold");
        wr(4'h0, 8'h01);
        wr(4'h4, 8'h00);
        pulses(4'h4);
        chk("irq_masked", {7'h0, irq}, 8'h00);
        mask <= 1'b0;
        repeat (3) @(posedge clock_in);
        chk("irq", {7'h0, irq}, 8'h01);
        rc(4'h2, 8'h01, "status_ovf2");
        rc(4'h4, 8'h00, "prim_lo2");
        repeat (3) @(posedge clock_in);
        chk("irq_clr", {7'h0, irq}, 8'h00);
        mask <= 1'b1;
        wr(4'h1, 8'h17);
        wr(4'h0, 8'h10);
        wr(4'hb, 8'h00);
        wr(4'hc, 8'h03);
        wr(4'h4, 8'h00);
        pulses(4'h8);
        chk("pin_match", {6'h0, cmp_pin}, 8'h01);
        chk("pin_oe", {6'h0, cmp_oe}, 8'h01);
        rc(4'h2, 8'h09, "status_cmp");
        wr(4'h0, 8'h00);
        wr(4'hb, 8'h00);
        wr(4'h4, 8'h00);
        pulses(4'h8);
        chk("pin_inhibit", {6'h0, cmp_pin}, 8'h01);
        wr(4'hc, 8'h03);
        rd(4'h2, d);
        chk("cmp_flag_clr", {7'h0, d[3]}, 8'h00);
        wr(4'h4, 8'h00);
        pulses(4'h8);
        chk("pin_level0", {6'h0, cmp_pin}, 8'h00);
        wr(4'h0, 8'h08);
        wr(4'h4, 8'h00);
        pulses(4'h2);
        cap_lvl <= 2'h1;
        repeat (6) @(posedge clock_in);
        rd(4'h2, d);
        chk("cap_flags", {6'h0, d[2:1]}, 8'h01);
        rc(4'h7, 8'hff, "cap1_hi");
        rc(4'h8, 8'hfe, "cap1_lo");
        rd(4'h2, d);
        chk("cap1_clr", {7'h0, d[1]}, 8'h00);
        rc(4'h7, 8'hff, "cap1_hi_blk");
        pulses(4'h1);
        cap_lvl <= 2'h0;
        repeat (6) @(posedge clock_in);
        cap_lvl <= 2'h1;
        repeat (6) @(posedge clock_in);
        rd(4'h2, d);
        chk("cap1_blocked", {7'h0, d[1]}, 8'h00);
        rc(4'h8, 8'hfe, "cap1_frozen");
        wr(4'h1, 8'h5f);
        cap_lvl <= 2'h0;
        repeat (6) @(posedge clock_in);
        cap_lvl <= 2'h3;
        repeat (6) @(posedge clock_in);
        rd(4'h2, d);
        chk("pulse_caps", {6'h0, d[2:1]}, 8'h02);
        rc(4'h9, 8'hff, "cap2_hi");
        rc(4'ha, 8'hff, "cap2_lo");
        // mid-run reset: the counter restarts from the reset count
        rst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        rc(4'h3, 8'hff, "rst_cnt_hi");
        rc(4'h4, 8'hfc, "rst_cnt_lo");
        summarize();
    end
endmodule // tb_free_running_timer_capture_compare
